//--- bpmc_regs.svh
`ifndef BPMC_REGS_SVH
`define BPMC_REGS_SVH

// Register word offsets (byte addresses in configuration space)
`define BPMC_OFF_PM_CAP 8'h80
`define BPMC_OFF_PM_CTRL 8'h84
`define BPMC_OFF_TIMEOUT 8'h88
`define BPMC_OFF_NEXT_CAP 8'h90

// Capability header contents
`define BPMC_PM_CAP_ID 8'h01
`define BPMC_PM_NEXT_PTR 8'h90
`define BPMC_PM_REVISION 3'h2
`define BPMC_NEXT_CAP_ID 8'h06
`define BPMC_NEXT_CAP_PTR 8'h00

// Field positions in the capability dword
`define BPMC_CAP_ID_LSB 0
`define BPMC_CAP_PTR_LSB 8
`define BPMC_CAP_REV_LSB 16
`define BPMC_CAP_D1_BIT 25
`define BPMC_CAP_D2_BIT 26

// Field positions in the control dword
`define BPMC_PS_LSB 0
`define BPMC_CLK_STOP_BIT 22
`define BPMC_STRAP_BIT 23

// Field positions in the timeout dword
`define BPMC_PRI_TMO_LSB 0
`define BPMC_SEC_TMO_LSB 16

// Reset values
`define BPMC_TMO_RESET 16'h8000
`define BPMC_PS_RESET 2'h0

// Internal chip reset pulse length after a D3 to D0 write
`define BPMC_SOFT_RST_NS 80
`define BPMC_CLK_PERIOD_NS 5
`define BPMC_SOFT_RST_CYCLES ((`BPMC_SOFT_RST_NS + `BPMC_CLK_PERIOD_NS - 1) / `BPMC_CLK_PERIOD_NS)

`endif

//--- bpmc_pkg.sv
package bpmc_pkg;

    // Power states of the bridge
    typedef enum logic [1:0] {
        BPMC_D0 = 2'b00,
        BPMC_D1 = 2'b01,
        BPMC_D2 = 2'b10,
        BPMC_D3 = 2'b11
    } bpmc_pstate_type;

    // Internal reset sequencer states
    typedef enum logic [0:0] {
        BPMC_RUN = 1'b0,
        BPMC_SOFT_RST = 1'b1
    } bpmc_rst_state_type;

    // Timeout counter states
    typedef enum logic [1:0] {
        BPMC_TMO_IDLE = 2'b00,
        BPMC_TMO_COUNT = 2'b01,
        BPMC_TMO_DONE = 2'b10
    } bpmc_tmo_state_type;

endpackage

//--- bpmc_timeout_counter.sv
`timescale 1ns/1ps

module bpmc_timeout_counter
    import bpmc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic clear_i, // Internal chip reset
    input wire logic pending_i, // Completed delayed transaction waits
    input wire logic [WIDTH-1:0] limit_i, // Programmed timeout in clocks
    output logic discard_o // One-cycle discard pulse
);

    bpmc_tmo_state_type state_q, state_d; // Counter state
    logic [WIDTH-1:0] count_q, count_d; // Clocks waited so far
    logic discard_q, discard_d; // Registered discard pulse
    logic [WIDTH:0] count_next; // Count plus one, one bit wider

    assign count_next = {1'b0, count_q} + {{WIDTH{1'b0}}, 1'b1};

    // Next state: count while pending, discard on reaching the limit
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        discard_d = 1'b0;
        case (state_q)
            BPMC_TMO_IDLE: begin
                count_d = '0;
                if (pending_i) begin
                    state_d = BPMC_TMO_COUNT;
                end
            end
            BPMC_TMO_COUNT: begin
                if (!pending_i) begin
                    // Initiator retried in time
                    state_d = BPMC_TMO_IDLE;
                    count_d = '0;
                end else if (count_next >= {1'b0, limit_i}) begin
                    state_d = BPMC_TMO_DONE;
                    discard_d = 1'b1;
                end else begin
                    count_d = count_next[WIDTH-1:0];
                end
            end
            BPMC_TMO_DONE: begin
                // Wait until the discarded transaction is gone
                count_d = '0;
                if (!pending_i) begin
                    state_d = BPMC_TMO_IDLE;
                end
            end
            default: begin
                state_d = BPMC_TMO_IDLE;
                count_d = '0;
            end
        endcase
        if (clear_i) begin
            state_d = BPMC_TMO_IDLE;
            count_d = '0;
            discard_d = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= BPMC_TMO_IDLE;
            count_q <= '0;
            discard_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            discard_q <= discard_d;
        end
    end

    assign discard_o = discard_q;

endmodule // bpmc_timeout_counter

//--- bpmc_regbank.sv
`timescale 1ns/1ps
`include "bpmc_regs.svh"

module bpmc_regbank
    import bpmc_pkg::*;
#(
    parameter int TMO_WIDTH = 16,
    parameter logic [3:0] PSTATE_IMPL = 4'hF,
    parameter int SOFT_RST_CYCLES = `BPMC_SOFT_RST_CYCLES
) (
    input wire logic clk_sys_i, // System clock, 200 MHz
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic [7:0] cfg_addr_i, // Configuration byte address
    input wire logic [31:0] cfg_wdata_i, // Write data
    input wire logic [3:0] cfg_be_i, // Byte enables, active high
    input wire logic cfg_wr_i, // Write strobe
    input wire logic cfg_rd_i, // Read strobe
    output logic [31:0] cfg_rdata_o, // Read data, one cycle later
    input wire logic bus_power_clock_strap_i, // Strap pin, asynchronous
    input wire logic sec_bus_reset_req_i, // Secondary reset request
    input wire logic pri_dly_pending_i, // Primary delayed completion waits
    input wire logic sec_dly_pending_i, // Secondary delayed completion waits
    output logic chip_soft_reset_o, // Internal chip reset, active high
    output logic sec_bus_reset_o, // Secondary bus reset, active high
    output logic [1:0] power_state_o, // Current power state
    output logic d3hot_clock_stop_o, // Drive secondary clocks low
    output logic pri_discard_o, // Primary transaction discard pulse
    output logic sec_discard_o // Secondary transaction discard pulse
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////

    localparam int RST_CNT_W = 8;
    localparam logic [RST_CNT_W-1:0] RST_LEN = RST_CNT_W'(SOFT_RST_CYCLES);

    logic strap_meta_q; // First synchroniser stage
    logic strap_sync_q; // Second synchroniser stage

    bpmc_pstate_type pstate_q, pstate_d; // Power state field
    logic [TMO_WIDTH-1:0] pri_tmo_q, pri_tmo_d; // Primary timeout value
    logic [TMO_WIDTH-1:0] sec_tmo_q, sec_tmo_d; // Secondary timeout value
    logic [31:0] rdata_q, rdata_d; // Read data register

    bpmc_rst_state_type rst_state_q, rst_state_d; // Reset sequencer
    logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d; // Soft reset length
    logic soft_rst_q, soft_rst_d; // Soft reset output flop
    logic sec_rst_q, sec_rst_d; // Secondary reset output flop
    logic clk_stop_q, clk_stop_d; // Clock stop output flop

    logic sel_cap; // Access hits capability dword
    logic sel_ctrl; // Access hits control dword
    logic sel_tmo; // Access hits timeout dword
    logic sel_next; // Access hits next capability dword
    logic wr_ctrl_b0; // Write to power state byte
    logic [1:0] ps_wdata; // Power state write value
    logic ps_legal; // Written state is implemented
    logic d3_to_d0; // Write leaves D3 for D0
    logic [31:0] cap_word; // Capability dword image
    logic [31:0] ctrl_word; // Control dword image
    logic [31:0] tmo_word; // Timeout dword image
    logic [31:0] next_word; // Next capability dword image

    ////////////////////////////////////////////////////////////////////
    // Address decode
    ////////////////////////////////////////////////////////////////////

    // Word select from the dword address, byte lanes from enables
    assign sel_cap = ({cfg_addr_i[7:2], 2'b00} == `BPMC_OFF_PM_CAP);
    assign sel_ctrl = ({cfg_addr_i[7:2], 2'b00} == `BPMC_OFF_PM_CTRL);
    assign sel_tmo = ({cfg_addr_i[7:2], 2'b00} == `BPMC_OFF_TIMEOUT);
    assign sel_next = ({cfg_addr_i[7:2], 2'b00} == `BPMC_OFF_NEXT_CAP);

    // Power state write only through the low byte lane
    assign wr_ctrl_b0 = cfg_wr_i && sel_ctrl && cfg_be_i[0];
    assign ps_wdata = cfg_wdata_i[`BPMC_PS_LSB +: 2];
    assign ps_legal = PSTATE_IMPL[ps_wdata];
    assign d3_to_d0 = wr_ctrl_b0 && (pstate_q == BPMC_D3) && (ps_wdata == BPMC_D0);

    ////////////////////////////////////////////////////////////////////
    // Strap synchroniser
    ////////////////////////////////////////////////////////////////////

    // Two stages before the strap is used anywhere
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
        end else begin
            strap_meta_q <= bus_power_clock_strap_i;
            strap_sync_q <= strap_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read images
    ////////////////////////////////////////////////////////////////////

    // Capability dword: constants only, all other bits zero
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[`BPMC_CAP_ID_LSB +: 8] = `BPMC_PM_CAP_ID;
        cap_word[`BPMC_CAP_PTR_LSB +: 8] = `BPMC_PM_NEXT_PTR;
        cap_word[`BPMC_CAP_REV_LSB +: 3] = `BPMC_PM_REVISION;
        cap_word[`BPMC_CAP_D1_BIT] = 1'b1;
        cap_word[`BPMC_CAP_D2_BIT] = 1'b1;
    end

    // Control dword: state field plus strap-reflected bits
    always_comb begin
        // PME bits, data fields, reserved bits and data byte are zero
        ctrl_word = 32'h0000_0000;
        ctrl_word[`BPMC_PS_LSB +: 2] = pstate_q;
        ctrl_word[`BPMC_CLK_STOP_BIT] = strap_sync_q;
        ctrl_word[`BPMC_STRAP_BIT] = strap_sync_q;
    end

    // Timeout dword: both counter limits
    always_comb begin
        tmo_word = 32'h0000_0000;
        tmo_word[`BPMC_PRI_TMO_LSB +: 16] = pri_tmo_q;
        tmo_word[`BPMC_SEC_TMO_LSB +: 16] = sec_tmo_q;
    end

    // Header of the following capability structure
    always_comb begin
        next_word = 32'h0000_0000;
        next_word[`BPMC_CAP_ID_LSB +: 8] = `BPMC_NEXT_CAP_ID;
        next_word[`BPMC_CAP_PTR_LSB +: 8] = `BPMC_NEXT_CAP_PTR;
    end

    ////////////////////////////////////////////////////////////////////
    // Register file next values
    ////////////////////////////////////////////////////////////////////

    // Writes by byte lane; soft reset restores the defaults
    always_comb begin
        pstate_d = pstate_q;
        pri_tmo_d = pri_tmo_q;
        sec_tmo_d = sec_tmo_q;
        if (soft_rst_q) begin
            // Whole chip reset brings back reset values
            pstate_d = BPMC_D0;
            pri_tmo_d = `BPMC_TMO_RESET;
            sec_tmo_d = `BPMC_TMO_RESET;
        end else if (cfg_wr_i) begin
            // Power state: illegal values are silently dropped
            if (wr_ctrl_b0 && ps_legal) begin
                pstate_d = bpmc_pstate_type'(ps_wdata);
            end
            // Primary timeout, low and high byte
            if (sel_tmo && cfg_be_i[0]) begin
                pri_tmo_d[7:0] = cfg_wdata_i[7:0];
            end
            if (sel_tmo && cfg_be_i[1]) begin
                pri_tmo_d[15:8] = cfg_wdata_i[15:8];
            end
            // Secondary timeout, low and high byte
            if (sel_tmo && cfg_be_i[2]) begin
                sec_tmo_d[7:0] = cfg_wdata_i[23:16];
            end
            if (sel_tmo && cfg_be_i[3]) begin
                sec_tmo_d[15:8] = cfg_wdata_i[31:24];
            end
        end
    end

    // Read data: valid only in the cycle after the strobe
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (cfg_rd_i) begin
            if (sel_cap) begin
                rdata_d = cap_word;
            end else if (sel_ctrl) begin
                rdata_d = ctrl_word;
            end else if (sel_tmo) begin
                rdata_d = tmo_word;
            end else if (sel_next) begin
                rdata_d = next_word;
            end else begin
                // Unmapped address reads zero
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // Register file flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pstate_q <= BPMC_D0;
            pri_tmo_q <= `BPMC_TMO_RESET;
            sec_tmo_q <= `BPMC_TMO_RESET;
            rdata_q <= 32'h0000_0000;
        end else begin
            pstate_q <= pstate_d;
            pri_tmo_q <= pri_tmo_d;
            sec_tmo_q <= sec_tmo_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Internal reset sequencer
    ////////////////////////////////////////////////////////////////////

    // Holds chip reset for a fixed time after a D3 to D0 write
    always_comb begin
        rst_state_d = rst_state_q;
        rst_cnt_d = rst_cnt_q;
        soft_rst_d = 1'b0;
        case (rst_state_q)
            BPMC_RUN: begin
                rst_cnt_d = '0;
                if (d3_to_d0) begin
                    rst_state_d = BPMC_SOFT_RST;
                    soft_rst_d = 1'b1;
                end
            end
            BPMC_SOFT_RST: begin
                if (rst_cnt_q + 8'h01 >= RST_LEN) begin
                    // Pulse length reached, release
                    rst_state_d = BPMC_RUN;
                    rst_cnt_d = '0;
                end else begin
                    rst_cnt_d = rst_cnt_q + 8'h01;
                    soft_rst_d = 1'b1;
                end
            end
            default: begin
                rst_state_d = BPMC_RUN;
                rst_cnt_d = '0;
            end
        endcase
    end

    // Outputs toward the rest of the bridge
    always_comb begin
        // Secondary reset is masked while the chip resets itself
        sec_rst_d = sec_bus_reset_req_i && !soft_rst_d;
        // Secondary clocks stop only in D3 with the strap high
        clk_stop_d = strap_sync_q && (pstate_d == BPMC_D3) && !soft_rst_d;
    end

    // Sequencer and output flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_state_q <= BPMC_RUN;
            rst_cnt_q <= '0;
            soft_rst_q <= 1'b0;
            sec_rst_q <= 1'b0;
            clk_stop_q <= 1'b0;
        end else begin
            rst_state_q <= rst_state_d;
            rst_cnt_q <= rst_cnt_d;
            soft_rst_q <= soft_rst_d;
            sec_rst_q <= sec_rst_d;
            clk_stop_q <= clk_stop_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Master timeout counters
    ////////////////////////////////////////////////////////////////////

    // Primary side delayed completion timer
    bpmc_timeout_counter #(
        .WIDTH(TMO_WIDTH)
    ) u_pri_tmo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(soft_rst_q),
        .pending_i(pri_dly_pending_i),
        .limit_i(pri_tmo_q),
        .discard_o(pri_discard_o)
    );

    // Secondary side delayed completion timer
    bpmc_timeout_counter #(
        .WIDTH(TMO_WIDTH)
    ) u_sec_tmo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(soft_rst_q),
        .pending_i(sec_dly_pending_i),
        .limit_i(sec_tmo_q),
        .discard_o(sec_discard_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Output assignments
    ////////////////////////////////////////////////////////////////////

    assign cfg_rdata_o = rdata_q;
    assign chip_soft_reset_o = soft_rst_q;
    assign sec_bus_reset_o = sec_rst_q;
    assign power_state_o = pstate_q;
    assign d3hot_clock_stop_o = clk_stop_q;

endmodule // bpmc_regbank

//--- bpmc_regbank_monitor.sv
`timescale 1ns/1ps

module bpmc_regbank_monitor
    import bpmc_pkg::*;
#(
    parameter int TMO_WIDTH = 16,
    parameter logic [3:0] PSTATE_IMPL = 4'hF,
    parameter int SOFT_RST_CYCLES = 16
) (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_n_i, // Reset, active low
    input wire logic [7:0] cfg_addr_i, // Byte address
    input wire logic [31:0] cfg_wdata_i, // Write data
    input wire logic [3:0] cfg_be_i, // Byte enables
    input wire logic cfg_wr_i, // Write strobe
    input wire logic cfg_rd_i, // Read strobe
    input wire logic [31:0] cfg_rdata_o, // Read data
    input wire logic bus_power_clock_strap_i, // Strap pin
    input wire logic sec_bus_reset_req_i, // Secondary reset request
    input wire logic pri_dly_pending_i, // Primary completion waits
    input wire logic sec_dly_pending_i, // Secondary completion waits
    input wire logic chip_soft_reset_o, // Internal chip reset
    input wire logic sec_bus_reset_o, // Secondary bus reset
    input wire logic [1:0] power_state_o, // Power state
    input wire logic d3hot_clock_stop_o, // Clock stop
    input wire logic pri_discard_o, // Primary discard pulse
    input wire logic sec_discard_o // Secondary discard pulse
);

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////////////
    // Helper logic
    logic [5:0] dw_sel; // Selected dword
    logic [1:0] ps_val; // Written power state
    logic ps_wr; // Power state write that is not blocked
    logic [7:0] rst_len_q; // Length of the running internal reset
    logic [7:0] rst_len_d; // Next length

    assign dw_sel = cfg_addr_i[7:2];
    assign ps_val = cfg_wdata_i[1:0];
    assign ps_wr = cfg_wr_i && dw_sel == 6'h21 && cfg_be_i[0] && !chip_soft_reset_o;

    // Count the cycles the internal reset stands
    always_comb begin
        rst_len_d = chip_soft_reset_o ? rst_len_q + 8'h01 : 8'h00;
    end

    // Register the count
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_len_q <= 8'h00;
        end else begin
            rst_len_q <= rst_len_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_rdata_idle_zero: assert property (!$past(cfg_rd_i) |-> cfg_rdata_o == 32'h0)
        else $error("read data not zero outside the answer cycle");
    a_cap_dword_value: assert property ($past(cfg_rd_i) && $past(dw_sel) == 6'h20 |-> cfg_rdata_o == 32'h06029001)
        else $error("capability dword wrong");
    a_ctrl_dword_fields: assert property ($past(cfg_rd_i) && $past(dw_sel) == 6'h21 |-> cfg_rdata_o[31:24] == 8'h00 && cfg_rdata_o[21:2] == 20'h0 && cfg_rdata_o[23] == cfg_rdata_o[22] && cfg_rdata_o[1:0] == $past(power_state_o))
        else $error("control dword fields wrong");
    a_second_cap_value: assert property ($past(cfg_rd_i) && $past(dw_sel) == 6'h24 |-> cfg_rdata_o == 32'h00000006)
        else $error("second capability dword wrong");
    a_pstate_taken: assert property (ps_wr && PSTATE_IMPL[ps_val] |=> power_state_o == $past(ps_val))
        else $error("power state write not taken");
    a_pstate_refused: assert property (ps_wr && !PSTATE_IMPL[ps_val] |=> $stable(power_state_o))
        else $error("unimplemented power state changed the field");
    a_soft_rst_start: assert property (ps_wr && ps_val == 2'b00 && power_state_o == 2'b11 |=> chip_soft_reset_o)
        else $error("no internal reset after leaving D3");
    a_soft_rst_length: assert property ($fell(chip_soft_reset_o) |-> rst_len_q == SOFT_RST_CYCLES)
        else $error("internal reset length wrong");
    a_no_sec_reset: assert property (chip_soft_reset_o |-> !sec_bus_reset_o)
        else $error("secondary reset during internal reset");
    a_pri_discard_pulse: assert property (pri_discard_o |-> $past(pri_dly_pending_i) ##1 !pri_discard_o)
        else $error("primary discard without pending or too long");
    a_sec_discard_pulse: assert property (sec_discard_o |-> $past(sec_dly_pending_i) ##1 !sec_discard_o)
        else $error("secondary discard without pending or too long");
    a_clock_stop_d3: assert property (d3hot_clock_stop_o |-> power_state_o == 2'b11)
        else $error("clock stop outside D3");

    // Main scenarios
    c_soft_reset: cover property ($rose(chip_soft_reset_o));
    c_pri_discard: cover property (pri_discard_o);
    c_refused: cover property (ps_wr && !PSTATE_IMPL[ps_val]);
    c_clock_stop: cover property (d3hot_clock_stop_o);

endmodule // bpmc_regbank_monitor

bind bpmc_regbank bpmc_regbank_monitor #(.TMO_WIDTH(TMO_WIDTH), .PSTATE_IMPL(PSTATE_IMPL),
    .SOFT_RST_CYCLES(SOFT_RST_CYCLES)) bpmc_regbank_monitor_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .bus_power_clock_strap_i(bus_power_clock_strap_i),
    .sec_bus_reset_req_i(sec_bus_reset_req_i), .pri_dly_pending_i(pri_dly_pending_i),
    .sec_dly_pending_i(sec_dly_pending_i), .chip_soft_reset_o(chip_soft_reset_o),
    .sec_bus_reset_o(sec_bus_reset_o), .power_state_o(power_state_o), .d3hot_clock_stop_o(d3hot_clock_stop_o),
    .pri_discard_o(pri_discard_o), .sec_discard_o(sec_discard_o));

//--- tb_bridge_power_mgmt_capability_regs.sv
`timescale 1ns/1ps

module tb_bridge_power_mgmt_capability_regs;

    localparam int SOFT_RST = 2; // Short internal reset for the run
    logic clk_sys_i, reset_n_i, cfg_wr_i, cfg_rd_i, strap, sec_req, pri_p, sec_p;
    logic [7:0] cfg_addr_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o;
    logic [3:0] cfg_be_i;
    logic soft_rst, sec_rst, clk_stop, pri_dis, sec_dis;
    logic [1:0] pstate;
    int fail_count = 0;
    int checks_done = 0;

    // D2 left unimplemented so refused writes can be seen
    bpmc_regbank #(.TMO_WIDTH(16), .PSTATE_IMPL(4'hB), .SOFT_RST_CYCLES(SOFT_RST)) bpmc_regbank_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_be_i(cfg_be_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
        .bus_power_clock_strap_i(strap), .sec_bus_reset_req_i(sec_req), .pri_dly_pending_i(pri_p),
        .sec_dly_pending_i(sec_p), .chip_soft_reset_o(soft_rst), .sec_bus_reset_o(sec_rst),
        .power_state_o(pstate), .d3hot_clock_stop_o(clk_stop), .pri_discard_o(pri_dis), .sec_discard_o(sec_dis));

    ////////////////////////////////////////////////////////////////////////
    // Bus and compare tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys_i);
        cfg_addr_i <= a;
        cfg_wdata_i <= d;
        cfg_be_i <= be;
        cfg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        cfg_wr_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_i);
        cfg_addr_i <= a;
        cfg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        cfg_rd_i <= 1'b0;
        #1;
        check(cfg_rdata_o, exp, what);
    endtask

    task automatic ps_step(input logic [31:0] d, input logic [3:0] be, input logic [1:0] exp);
        wr(8'h84, d, be);
        rdchk(8'h84, {8'h00, 2'b11, 20'h0, exp}, "power state field");
        check({30'h0, pstate}, {30'h0, exp}, "power state output");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_fixed_values();
        rdchk(8'h80, 32'h06029001, "capability dword");
        rdchk(8'h84, 32'h00C00000, "control dword");
        rdchk(8'h88, 32'h80008000, "timeout dword");
        rdchk(8'h90, 32'h00000006, "second capability");
        rdchk(8'h8C, 32'h00000000, "unmapped dword");
        wr(8'h80, 32'hFFFFFFFF, 4'hF);
        wr(8'h90, 32'hFFFFFFFF, 4'hF);
        wr(8'h8C, 32'hFFFFFFFF, 4'hF);
        rdchk(8'h80, 32'h06029001, "capability after write");
        rdchk(8'h90, 32'h00000006, "second capability after write");
        rdchk(8'h8C, 32'h00000000, "unmapped after write");
        @(posedge clk_sys_i);
        #1;
        check(cfg_rdata_o, 32'h0, "read data after answer");
    endtask

    task automatic t_timeouts();
        wr(8'h88, 32'h12345678, 4'hF);
        rdchk(8'h88, 32'h12345678, "timeouts written");
        wr(8'h88, 32'hFFFFFFFF, 4'h1);
        rdchk(8'h88, 32'h123456FF, "low byte only");
        wr(8'h88, 32'hABCD0000, 4'hC);
        rdchk(8'h88, 32'hABCD56FF, "secondary bytes only");
    endtask

    task automatic t_power_states();
        ps_step(32'h00000001, 4'h1, 2'h1);
        ps_step(32'h00000002, 4'hF, 2'h1);
        ps_step(32'h00000000, 4'hE, 2'h1);
        ps_step(32'hFFFFFFFC, 4'hF, 2'h0);
        check({31'h0, soft_rst}, 32'h0, "no reset leaving D1");
        rdchk(8'h88, 32'hABCD56FF, "timeouts kept leaving D1");
        ps_step(32'h00000003, 4'h1, 2'h3);
        check({31'h0, clk_stop}, 32'h1, "clock stop in D3");
        @(posedge clk_sys_i);
        strap <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rdchk(8'h84, 32'h00000003, "strap low");
        check({31'h0, clk_stop}, 32'h0, "no clock stop, strap low");
        @(posedge clk_sys_i);
        strap <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic t_leave_d3();
        int n;
        n = 0;
        wr(8'h88, 32'h00010001, 4'hF);
        sec_req <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check({31'h0, sec_rst}, 32'h1, "secondary reset follows request");
        wr(8'h84, 32'h00000000, 4'h1);
        #1;
        while (soft_rst === 1'b1 && n < 20) begin
            check({31'h0, sec_rst}, 32'h0, "secondary reset during chip reset");
            n++;
            @(posedge clk_sys_i);
            #1;
        end
        check(32'(n), 32'(SOFT_RST), "chip reset length");
        rdchk(8'h88, 32'h80008000, "timeouts after chip reset");
        rdchk(8'h84, 32'h00C00000, "state after chip reset");
        @(posedge clk_sys_i);
        sec_req <= 1'b0;
    endtask

    task automatic t_discard(input int lim, input bit sec);
        int n;
        int extra;
        n = 0;
        extra = 0;
        wr(8'h88, {16'(lim), 16'(lim)}, 4'hF);
        if (sec) sec_p <= 1'b1;
        else pri_p <= 1'b1;
        while (n < 40 && (sec ? sec_dis : pri_dis) !== 1'b1) begin
            @(posedge clk_sys_i);
            #1;
            n++;
            if ((sec ? pri_dis : sec_dis) !== 1'b0) extra++;
        end
        check({31'h0, n >= lim - 1 && n <= lim + 3}, 32'h1, "discard delay");
        repeat (20) begin
            @(posedge clk_sys_i);
            #1;
            if (pri_dis !== 1'b0 || sec_dis !== 1'b0) extra++;
        end
        check(32'(extra), 32'h0, "stray discard pulses");
        @(posedge clk_sys_i);
        pri_p <= 1'b0;
        sec_p <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Closing, clock, watchdog and main sequence
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        finish_test();
    end

    initial begin
        reset_n_i = 1'b0;
        cfg_addr_i = 8'h00;
        cfg_wdata_i = 32'h0;
        cfg_be_i = 4'h0;
        cfg_wr_i = 1'b0;
        cfg_rd_i = 1'b0;
        strap = 1'b1;
        sec_req = 1'b0;
        pri_p = 1'b0;
        sec_p = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_fixed_values();
        t_timeouts();
        t_power_states();
        t_leave_d3();
        t_discard(4, 1'b0);
        t_discard(6, 1'b1);
        finish_test();
    end

endmodule // tb_bridge_power_mgmt_capability_regs
